/* File: verilog/emu_break_pkg.sv */
// Package with the constants shared by both ends of the emulation break link.
`default_nettype none
package emu_break_pkg;
  // Register indexes on the register port of the device end.
  localparam logic [2:0]  REG_CONTROL   = 3'h0;  // Emulation control register.
  localparam logic [2:0]  REG_STATUS    = 3'h1;  // Emulation status register.
  localparam logic [2:0]  REG_CMP_HIGH  = 3'h2;  // Compare address, upper half.
  localparam logic [2:0]  REG_CMP_LOW   = 3'h3;  // Compare address, lower half.
  localparam logic [2:0]  REG_MASK_HIGH = 3'h4;  // Compare mask, upper half.
  localparam logic [2:0]  REG_MASK_LOW  = 3'h5;  // Compare mask, lower half.
  // Control register bit positions.
  localparam int CTL_MATCH_ON    = 0;  // Comparison logic enable.
  localparam int CTL_BREAK_TYPE  = 1;  // 0 bus break, 1 program break.
  localparam int CTL_SINGLE      = 2;  // 1 single breakpoint, 0 multiple.
  localparam int CTL_FIXED_OFF   = 3;  // Disables the fixed vector words.
  localparam int CTL_BUS_IRQ_ON  = 4;  // Bus break raises the top level interrupt.
  localparam int CTL_WIDTH       = 5;  // Implemented control bits.
  // Status register bit positions.
  localparam int STS_EDGE        = 0;  // Request pin falling edge seen.
  localparam int STS_PROGRAM     = 1;  // Program breakpoint hit.
  localparam int STS_BUS         = 2;  // Bus breakpoint hit.
  localparam int STS_EMULATION   = 3;  // Emulation mode indication.
  localparam int STS_WIDTH       = 4;  // Implemented status bits.
  // Fixed vector addresses and the words returned for them.
  localparam logic [31:0] FIX_ADDR_0  = 32'h0000_0000;
  localparam logic [31:0] FIX_ADDR_2  = 32'h0000_0002;
  localparam logic [31:0] FIX_ADDR_4  = 32'h0000_0004;
  localparam logic [31:0] FIX_ADDR_6  = 32'h0000_0006;
  localparam logic [31:0] FIX_ADDR_28 = 32'h0000_0028;
  localparam logic [31:0] FIX_ADDR_2A = 32'h0000_002A;
  localparam logic [15:0] FIX_WORD_HI = 16'hFFFC;
  localparam logic [15:0] FIX_WORD_20 = 16'h0020;
  localparam logic [15:0] FIX_WORD_10 = 16'h0010;
  // Monitor ROM window.
  localparam logic [31:0] MON_ROM_FIRST = 32'hFFFC_0000;
  localparam logic [31:0] MON_ROM_LAST  = 32'hFFFC_FFFF;
  // Mask that leaves only the upper half to the internal comparator.
  localparam logic [31:0] UPPER_ONLY_MASK = 32'h0000_FFFF;
  // Request pulse driven by the emulator end.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int REQ_PULSE_NS   = 300;
  localparam int REQ_GAP_NS     = 300;
  localparam int REQ_PULSE_CYC  = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_GAP_CYC    = (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REQ_PULSE_LEN = 4'(REQ_PULSE_CYC);
  localparam logic [3:0] REQ_GAP_LEN   = 4'(REQ_GAP_CYC);
  // Emulator end request sequencer states.
  typedef enum logic [2:0]
  {
    REQ_IDLE  = 3'b001,
    REQ_PULSE = 3'b010,
    REQ_GAP   = 3'b100
  } req_state_t;
endpackage : emu_break_pkg
`default_nettype wire

/* File: verilog/emu_link_if.sv */
// Interface carrying the pins between the device end and the emulator end.
`default_nettype none
interface emu_link_if;
  logic        breakReqN;      // External break request pin, emulator drives it.
  logic        brkDevOut;      // Breakpoint line value from the device.
  logic        brkDevOeN;      // Device drives the breakpoint line while low.
  logic        brkEmuOut;      // Breakpoint line value from the emulator.
  logic        brkEmuOeN;      // Emulator drives the breakpoint line while low.
  logic        brkLevel;       // Resolved breakpoint line level.
  logic        monitorSelN;    // Monitor ROM select, active low.
  logic [15:0] linkAddrLow;    // Lower address bits for the external comparator.
  logic        linkAddrValid;  // Address bits above are valid.
  // The line is pulled high when nobody drives it.
  assign brkLevel = !brkDevOeN ? brkDevOut : (!brkEmuOeN ? brkEmuOut : 1'b1);
  modport device (input breakReqN, brkLevel, brkEmuOut, brkEmuOeN,
                  output brkDevOut, brkDevOeN, monitorSelN, linkAddrLow, linkAddrValid);
  modport emulator (input brkLevel, monitorSelN, linkAddrLow, linkAddrValid, brkDevOut,
                    brkDevOeN, output breakReqN, brkEmuOut, brkEmuOeN);
endinterface : emu_link_if
`default_nettype wire

/* File: verilog/emu_break_device.sv */
// Device end: emulation breakpoint compare, status flags and fixed vector words.
`default_nettype none
module emu_break_device
  import emu_break_pkg::*;
(
  input  wire logic        clk,            // Processor clock.
  input  wire logic        rstn,           // Synchronous reset, active low.
  input  wire logic        emuMode,        // Core runs in emulation mode.
  input  wire logic        regWe,          // Register write strobe.
  input  wire logic        regRe,          // Register read strobe.
  input  wire logic [2:0]  regSel,         // Register index.
  input  wire logic [15:0] regWdata,       // Register write data.
  output var  logic [15:0] regRdata,       // Register read data, valid after regRe.
  input  wire logic        busValid,       // A bus cycle is presented this clock.
  input  wire logic [31:0] busAddr,        // Bus cycle address.
  input  wire logic        busRead,        // Bus cycle is a read.
  input  wire logic        busProgram,     // Bus cycle is a program fetch.
  input  wire logic        vecFetch,       // Top level interrupt vector word fetch.
  input  wire logic        vecLower,       // Vector fetch of the lower word.
  output var  logic        fixedHit,       // Fixed word replaces external memory.
  output var  logic [15:0] fixedData,      // Fixed word value.
  output var  logic        topLevelInterrupt, // Level 7 interrupt request.
  output var  logic        breakEvent,     // Breakpoint raised, one clock pulse.
  emu_link_if.device       link            // Pins toward the emulator.
);
  logic [CTL_WIDTH-1:0] control;      // Control register bits.
  logic [31:0]          cmpAddr;      // Compare address.
  logic [31:0]          cmpMask;      // Compare mask, ones are don't care.
  logic                 busBreakFlag;      // Sticky bus break flag.
  logic                 programBreakFlag;  // Sticky program break flag.
  logic                 extBreakEdgeFlag;  // Sticky request pin edge flag.
  logic                 reqSync1;     // Request pin, first synchroniser stage.
  logic                 reqSync2;     // Request pin, second synchroniser stage.
  logic                 reqPrev;      // Request pin, previous synchronised level.
  logic                 reqFall;      // Falling edge of the request pin.
  logic                 upperHit;     // Last bus cycle matched the upper half.
  logic                 fullMatch;    // Current bus cycle fully matches.
  logic                 upperMatch;   // Current bus cycle matches the upper half.
  logic                 typeOk;       // Cycle kind fits the selected break type.
  logic                 next_break;   // A breakpoint is raised this clock.
  logic                 fixedActive;  // Fixed words are in force.
  logic [15:0]          next_fixed;   // Fixed word for the current read.
  logic                 next_fixedHit;  // Current read takes a fixed word.
  logic                 writeStatus;  // Status register write this clock.

  // Compare against the masked address; the full address and the upper half are checked separately so
  // that multiple breakpoint mode can leave the lower half to the emulator.
  assign fullMatch  = ((busAddr ^ cmpAddr) & ~cmpMask) == 32'h0000_0000;
  assign upperMatch = ((busAddr ^ cmpAddr) & ~(cmpMask | UPPER_ONLY_MASK)) == 32'h0000_0000;
  assign typeOk     = control[CTL_BREAK_TYPE] ? busProgram : 1'b1;
  assign reqFall    = reqPrev & ~reqSync2;
  assign writeStatus = regWe && (regSel == REG_STATUS);

  // Single mode breaks on a full internal match; multiple mode waits for the
  // emulator pulse after an upper half hit. Disabled compare never breaks.
  always_comb
  begin
    next_break = 1'b0;
    if (control[CTL_MATCH_ON])
    begin
      if (control[CTL_SINGLE])
      begin
        next_break = busValid && fullMatch && typeOk;
      end
      else
      begin
        next_break = reqFall && upperHit;
      end
    end
  end

  // Fixed words stand in only for reads in emulation mode with the disable
  // bit clear; writes always reach external memory.
  assign fixedActive = emuMode && !control[CTL_FIXED_OFF];
  always_comb
  begin
    next_fixed    = 16'h0000;
    next_fixedHit = 1'b0;
    if (fixedActive && busValid && busRead)
    begin
      next_fixedHit = 1'b1;
      if (vecFetch)
      begin
        next_fixed = vecLower ? FIX_WORD_10 : FIX_WORD_HI;
      end
      else
      begin
        case (busAddr)
          FIX_ADDR_0, FIX_ADDR_2, FIX_ADDR_4, FIX_ADDR_28: next_fixed = FIX_WORD_HI;
          FIX_ADDR_6:  next_fixed = FIX_WORD_20;
          FIX_ADDR_2A: next_fixed = FIX_WORD_10;
          default:     next_fixedHit = 1'b0;
        endcase
      end
    end
  end

  // Two stages bring the request pin into the clock domain before the edge
  // detector sees it; the idle level is high.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reqSync1 <= 1'b1;
      reqSync2 <= 1'b1;
      reqPrev  <= 1'b1;
    end
    else
    begin
      reqSync1 <= link.breakReqN;
      reqSync2 <= reqSync1;
      reqPrev  <= reqSync2;
    end
  end

  // Remember whether the last bus cycle hit the upper half, so a late pulse
  // from the external comparator can still pair with it.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      upperHit <= 1'b0;
    end
    else if (busValid)
    begin
      upperHit <= upperMatch && typeOk;
    end
  end

  // Writable control and compare registers.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      control <= '0;
      cmpAddr <= 32'h0000_0000;
      cmpMask <= 32'h0000_0000;
    end
    else if (regWe)
    begin
      case (regSel)
        REG_CONTROL:   control       <= regWdata[CTL_WIDTH-1:0];
        REG_CMP_HIGH:  cmpAddr[31:16] <= regWdata;
        REG_CMP_LOW:   cmpAddr[15:0]  <= regWdata;
        REG_MASK_HIGH: cmpMask[31:16] <= regWdata;
        REG_MASK_LOW:  cmpMask[15:0]  <= regWdata;
        default:       control       <= control;
      endcase
    end
  end

  // Sticky flags: a new event wins over a clear in the same clock, and zero
  // bits of a status write leave the flags alone.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      busBreakFlag     <= 1'b0;
      programBreakFlag <= 1'b0;
      extBreakEdgeFlag <= 1'b0;
    end
    else
    begin
      if (next_break && !control[CTL_BREAK_TYPE])
      begin
        busBreakFlag <= 1'b1;
      end
      else if (writeStatus && regWdata[STS_BUS])
      begin
        busBreakFlag <= 1'b0;
      end
      if (next_break && control[CTL_BREAK_TYPE])
      begin
        programBreakFlag <= 1'b1;
      end
      else if (writeStatus && regWdata[STS_PROGRAM])
      begin
        programBreakFlag <= 1'b0;
      end
      if (reqFall)
      begin
        extBreakEdgeFlag <= 1'b1;
      end
      else if (writeStatus && regWdata[STS_EDGE])
      begin
        extBreakEdgeFlag <= 1'b0;
      end
    end
  end

  // Read data is registered; the status word shows mode and flags, the rest reads zero.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      regRdata <= 16'h0000;
    end
    else if (regRe)
    begin
      case (regSel)
        REG_CONTROL:   regRdata <= {{(16-CTL_WIDTH){1'b0}}, control};
        REG_STATUS:    regRdata <= {{(16-STS_WIDTH){1'b0}}, emuMode, busBreakFlag,
                                    programBreakFlag, extBreakEdgeFlag};
        REG_CMP_HIGH:  regRdata <= cmpAddr[31:16];
        REG_CMP_LOW:   regRdata <= cmpAddr[15:0];
        REG_MASK_HIGH: regRdata <= cmpMask[31:16];
        REG_MASK_LOW:  regRdata <= cmpMask[15:0];
        default:       regRdata <= 16'h0000;
      endcase
    end
  end

  // Registered outputs toward the core and the link. The interrupt follows the sticky bus
  // break flag while its enable bit is set, so it stays up until software clears the flag or that bit.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fixedHit          <= 1'b0;
      fixedData         <= 16'h0000;
      topLevelInterrupt <= 1'b0;
      breakEvent        <= 1'b0;
      link.brkDevOut    <= 1'b1;
      link.brkDevOeN    <= 1'b1;
      link.monitorSelN  <= 1'b1;
      link.linkAddrLow  <= 16'h0000;
      link.linkAddrValid <= 1'b0;
    end
    else
    begin
      fixedHit          <= next_fixedHit;
      fixedData         <= next_fixed;
      topLevelInterrupt <= control[CTL_BUS_IRQ_ON] && busBreakFlag;
      breakEvent        <= next_break;
      link.brkDevOut    <= !next_break;
      link.brkDevOeN    <= !control[CTL_SINGLE];
      link.monitorSelN  <= !(emuMode && busValid && busAddr >= MON_ROM_FIRST
                             && busAddr <= MON_ROM_LAST);
      link.linkAddrLow  <= busAddr[15:0];
      link.linkAddrValid <= busValid;
    end
  end
endmodule : emu_break_device
`default_nettype wire

/* File: verilog/emu_break_emulator.sv */
// Emulator end: external lower address comparator and break request pulse.
`default_nettype none
module emu_break_emulator
  import emu_break_pkg::*;
(
  input  wire logic        clk,            // Processor clock.
  input  wire logic        rstn,           // Synchronous reset, active low.
  input  wire logic        extCmpOn,       // External comparator enabled.
  input  wire logic [15:0] extCmpAddr,     // Lower address bits to match.
  input  wire logic        abortReq,       // Manual abort, one clock pulse.
  output var  logic        requestBusy,    // A request pulse or the gap after it is in progress.
  output var  logic        breakSeen,      // Device breakpoint line went low.
  output var  logic        monitorActive,  // Device selects the monitor ROM.
  emu_link_if.emulator     link            // Pins toward the device.
);
  req_state_t  state;        // Request sequencer state.
  logic [3:0]  count;        // Cycles left in the current state.
  logic        brkSync1;     // Breakpoint line, first stage.
  logic        brkSync2;     // Breakpoint line, second stage.
  logic        brkPrev;      // Breakpoint line, previous level.
  logic        selSync1;     // Monitor select, first stage.
  logic        selSync2;     // Monitor select, second stage.
  logic [15:0] addrSync1;    // Lower address, first stage.
  logic [15:0] addrSync2;    // Lower address, second stage.
  logic        validSync1;   // Address valid, first stage.
  logic        validSync2;   // Address valid, second stage.
  logic        lowMatch;     // Lower address matches.

  assign lowMatch = extCmpOn && validSync2 && (addrSync2 == extCmpAddr);

  // Pin inputs pass two stages before any logic reads them.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      brkSync1   <= 1'b1;
      brkSync2   <= 1'b1;
      brkPrev    <= 1'b1;
      selSync1   <= 1'b1;
      selSync2   <= 1'b1;
      addrSync1  <= 16'h0000;
      addrSync2  <= 16'h0000;
      validSync1 <= 1'b0;
      validSync2 <= 1'b0;
    end
    else
    begin
      brkSync1   <= link.brkLevel;
      brkSync2   <= brkSync1;
      brkPrev    <= brkSync2;
      selSync1   <= link.monitorSelN;
      selSync2   <= selSync1;
      addrSync1  <= link.linkAddrLow;
      addrSync2  <= addrSync1;
      validSync1 <= link.linkAddrValid;
      validSync2 <= validSync1;
    end
  end

  // Pulse the request pin low for a fixed time, then hold it high for a gap
  // so the device edge detector always sees a clean high before the next fall.
  // Matches arriving during a pulse or gap are dropped, not queued.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= REQ_IDLE;
      count <= 4'h0;
    end
    else
    begin
      case (state)
        REQ_IDLE:
        begin
          if (lowMatch || abortReq)
          begin
            state <= REQ_PULSE;
            count <= REQ_PULSE_LEN - 4'h1;
          end
        end
        REQ_PULSE:
        begin
          if (count == 4'h0)
          begin
            state <= REQ_GAP;
            count <= REQ_GAP_LEN - 4'h1;
          end
          else
          begin
            count <= count - 4'h1;
          end
        end
        REQ_GAP:
        begin
          if (count == 4'h0)
          begin
            state <= REQ_IDLE;
          end
          else
          begin
            count <= count - 4'h1;
          end
        end
        default:
        begin
          state <= REQ_IDLE;
          count <= 4'h0;
        end
      endcase
    end
  end

  // Registered outputs; the emulator never drives the breakpoint line.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      link.breakReqN <= 1'b1;
      link.brkEmuOut <= 1'b1;
      link.brkEmuOeN <= 1'b1;
      requestBusy    <= 1'b0;
      breakSeen      <= 1'b0;
      monitorActive  <= 1'b0;
    end
    else
    begin
      link.breakReqN <= !((state == REQ_IDLE && (lowMatch || abortReq))
                          || (state == REQ_PULSE && count != 4'h0));
      link.brkEmuOut <= 1'b1;
      link.brkEmuOeN <= 1'b1;
      requestBusy    <= (state != REQ_IDLE) || lowMatch || abortReq;
      breakSeen      <= brkPrev && !brkSync2;
      monitorActive  <= !selSync2;
    end
  end
endmodule : emu_break_emulator
`default_nettype wire

/* File: testbench/emu_break_sva.sv */
// Checker for the pins that join the device end and the emulator end.
`default_nettype none
module emu_break_sva
(
  input wire logic        clk,           // Processor clock.
  input wire logic        rstn,          // Synchronous reset, active low.
  input wire logic        breakReqN,     // Break request pin.
  input wire logic        brkDevOut,     // Breakpoint line value from the device.
  input wire logic        brkDevOeN,     // Device drive enable, low drives.
  input wire logic        brkEmuOut,     // Breakpoint line value from the emulator.
  input wire logic        brkEmuOeN,     // Emulator drive enable, low drives.
  input wire logic        brkLevel,      // Resolved breakpoint line.
  input wire logic        monitorSelN,   // Monitor ROM select, active low.
  input wire logic [15:0] linkAddrLow,   // Lower address bits toward the emulator.
  input wire logic        linkAddrValid  // Lower address bits are valid.
);
  timeunit 1ns;
  timeprecision 1ns;
  // All pins share the processor clock, so one default domain serves.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // The request pulse is three clocks low and then returns high.
  AST_REQ_PULSE: assert property ($fell(breakReqN) |-> !breakReqN [*3] ##1 breakReqN)
    else $error("Break request pulse is not three clocks low.");
  // A gap of three high clocks keeps two pulses apart.
  AST_REQ_GAP: assert property ($rose(breakReqN) |-> breakReqN [*3])
    else $error("Break request gap is shorter than three clocks.");
  // A new pulse never starts inside the previous gap.
  AST_REQ_IDLE: assert property ($fell(breakReqN) |->
    $past(breakReqN, 2) && $past(breakReqN, 3))
    else $error("Break request pulse started inside a gap.");
  // The emulator end only listens to the breakpoint line.
  AST_EMU_OFF: assert property (brkEmuOeN && brkEmuOut)
    else $error("Emulator end drives the breakpoint line.");
  // With nobody driving, the pull-up holds the line high.
  AST_PULL_UP: assert property (brkDevOeN |-> brkLevel)
    else $error("Undriven breakpoint line is not high.");
  // While the device drives, the line shows its value.
  AST_DEV_LEVEL: assert property (!brkDevOeN |-> (brkLevel == brkDevOut))
    else $error("Breakpoint line differs from the device value.");
  // The monitor select follows a bus cycle of the same stage.
  AST_MON_VALID: assert property (!monitorSelN |-> linkAddrValid)
    else $error("Monitor select without a bus cycle.");
  // A single mode break comes from the bus cycle of the same stage.
  AST_BRK_VALID: assert property ((!brkDevOeN && !brkDevOut) |-> linkAddrValid)
    else $error("Breakpoint pulse without a bus cycle.");
  // Lower address bits reach the external comparator.
  COV_ADDR: cover property (linkAddrValid && linkAddrLow != 16'h0000);
endmodule : emu_break_sva
`default_nettype wire

/* File: testbench/test_emulation_break_status_logic.sv */
// Self-checking bench that joins the device end and the emulator end.
`default_nettype none
module test_emulation_break_status_logic
  import emu_break_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus, observed outputs and reference model state.
  logic        clk, rstn, emuMode, regWe, regRe, busValid, busRead, busProgram;
  logic        vecFetch, vecLower, extCmpOn, abortReq, fixedHit, topLevelInterrupt;
  logic        breakEvent, requestBusy, breakSeen, monitorActive;
  logic [2:0]  regSel;
  logic [15:0] regWdata, extCmpAddr, regRdata, fixedData, v, lo;
  logic [31:0] busAddr, cmp;
  int          failures, nTests, mSts, nBreaks, base, nMon, nSeen, nBusy;
  // Bus addresses with the word and select each one must give.
  int          ta[$] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0004, 32'h0000_0006,
                         32'h0000_0028, 32'h0000_002A, 32'h0000_0100, 32'h0000_0100,
                         32'hFFFC_0000, 32'hFFFC_FFFF, 32'hFFFB_FFFF, 32'hFFFD_0000};
  int          tw[$] = '{16'hFFFC, 16'hFFFC, 16'hFFFC, 16'h0020, 16'hFFFC, 16'h0010,
                         16'hFFFC, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  emu_link_if link ();
  emu_break_device emu_break_device_i (.clk(clk), .rstn(rstn), .emuMode(emuMode),
    .regWe(regWe), .regRe(regRe), .regSel(regSel), .regWdata(regWdata),
    .regRdata(regRdata), .busValid(busValid), .busAddr(busAddr), .busRead(busRead),
    .busProgram(busProgram), .vecFetch(vecFetch), .vecLower(vecLower),
    .fixedHit(fixedHit), .fixedData(fixedData), .topLevelInterrupt(topLevelInterrupt),
    .breakEvent(breakEvent), .link(link));
  emu_break_emulator emu_break_emulator_i (.clk(clk), .rstn(rstn), .extCmpOn(extCmpOn),
    .extCmpAddr(extCmpAddr), .abortReq(abortReq), .requestBusy(requestBusy),
    .breakSeen(breakSeen), .monitorActive(monitorActive), .link(link));
  emu_break_sva emu_break_sva_i (.clk(clk), .rstn(rstn), .breakReqN(link.breakReqN),
    .brkDevOut(link.brkDevOut), .brkDevOeN(link.brkDevOeN), .brkEmuOut(link.brkEmuOut),
    .brkEmuOeN(link.brkEmuOeN), .brkLevel(link.brkLevel), .monitorSelN(link.monitorSelN),
    .linkAddrLow(link.linkAddrLow), .linkAddrValid(link.linkAddrValid));
  // The clock runs at 10 MHz.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Pulses and busy cycles are counted, since a late pulse would slip past a single look.
  always @(posedge clk)
  begin
    nBreaks += int'(breakEvent === 1'b1);
    nMon    += int'(monitorActive === 1'b1);
    nSeen   += int'(breakSeen === 1'b1);
    nBusy   += int'(requestBusy === 1'b1);
  end
  // Compares a value seen with its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (failures == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Register write; the strobe is taken at the second edge.
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    regWe <= 1'b1;
    regSel <= s;
    regWdata <= d;
    @(posedge clk);
    regWe <= 1'b0;
  endtask : wr
  // Register read; data is looked at once the answering edge has landed.
  task automatic rd(input logic [2:0] s);
    @(posedge clk);
    regRe <= 1'b1;
    regSel <= s;
    @(posedge clk);
    regRe <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask : rd
  // One bus cycle; outputs of that cycle are looked at half a clock later.
  task automatic bus(input logic [31:0] a, input logic r, p, vf, vl);
    @(posedge clk);
    {busValid, busRead, busProgram, vecFetch, vecLower} <= {1'b1, r, p, vf, vl};
    busAddr <= a;
    @(posedge clk);
    busValid <= 1'b0;
    @(negedge clk);
  endtask : bus
  // Status must show the mode and the model's flags.
  task automatic stsChk;
    rd(REG_STATUS);
    chk(v, 16'(mSts + (emuMode ? 8 : 0)));
  endtask : stsChk
  // Waits for the emulator request, pulse and gap, to finish.
  task automatic waitIdle;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 30 && requestBusy !== 1'b0; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : waitIdle
  // Cuts a hang short.
  initial
  begin
    #1_000_000;
    failures++;
    print_verdict();
  end
  // Main sequence.
  initial
  begin
    {rstn, emuMode, regWe, regRe, busValid, busRead, busProgram} = '0;
    {vecFetch, vecLower, extCmpOn, abortReq, regSel, regWdata, extCmpAddr, busAddr} = '0;
    v = 16'($urandom(49662));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CONTROL);
    chk(v, 16'h0000);
    stsChk();
    repeat (4)
    begin
      lo = 16'($urandom);
      wr(REG_CONTROL, lo);
      wr(3'h6, lo);
      rd(REG_CONTROL);
      chk(v, lo & 16'h001F);
      rd(3'h6);
      chk(v, 16'h0000);
    end
    @(posedge clk);
    emuMode <= 1'b1;
    stsChk();
    @(posedge clk);
    emuMode <= 1'b0;
    // Compare registers are set up before the enable bit.
    cmp = {4'h1, 28'($urandom)};
    wr(REG_CMP_HIGH, cmp[31:16]);
    wr(REG_CMP_LOW, cmp[15:0]);
    wr(REG_CONTROL, 16'h0014);
    bus(cmp, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(16'(breakEvent), 16'h0000);
    for (int t = 0; t < 2; t++)
    begin
      wr(REG_CONTROL, 16'h0015 | 16'(t << 1));
      bus(cmp, 1'b1, 1'b0, 1'b0, 1'b0);
      chk(16'(breakEvent), 16'(t == 0));
      bus(cmp ^ 32'h0001_0000, 1'b1, 1'b1, 1'b0, 1'b0);
      chk(16'(breakEvent), 16'h0000);
      bus(cmp, 1'b1, 1'b1, 1'b0, 1'b0);
      chk(16'(breakEvent), 16'h0001);
      chk(16'(topLevelInterrupt), 16'(t == 0));
      mSts = (t == 0) ? 4 : 2;
      stsChk();
      wr(REG_STATUS, 16'h0000);
      stsChk();
      wr(REG_STATUS, 16'(mSts));
      mSts = 0;
      stsChk();
    end
    wr(REG_CONTROL, 16'h0005);
    bus(cmp, 1'b1, 1'b0, 1'b0, 1'b0);
    @(negedge clk);
    chk(16'(topLevelInterrupt), 16'h0000);
    wr(REG_STATUS, 16'h0004);
    wr(REG_CONTROL, 16'h0000);
    emuMode <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      bus(32'(ta[i]), 1'b1, 1'b0, i == 6 || i == 7, i == 7);
      chk(16'(fixedHit), 16'(tw[i] != 0));
      chk(fixedData, 16'(tw[i]));
      chk(16'(link.monitorSelN), 16'(i < 8 || i > 9));
    end
    // Writes, the disable bit and normal mode each keep external memory.
    for (int k = 0; k < 3; k++)
    begin
      wr(REG_CONTROL, 16'(k == 1) << 3);
      emuMode <= (k != 2);
      bus(32'h0000_0000, k != 0, 1'b0, 1'b0, 1'b0);
      chk(16'(fixedHit), 16'h0000);
    end
    chk(16'(nMon), 16'h0002);
    @(posedge clk);
    abortReq <= 1'b1;
    @(posedge clk);
    abortReq <= 1'b0;
    base = nBreaks;
    waitIdle();
    mSts = 1;
    stsChk();
    chk(16'(nBreaks - base), 16'h0000);
    chk(16'(nBusy), 16'(REQ_PULSE_CYC + REQ_GAP_CYC + 1));
    wr(REG_STATUS, 16'h0001);
    mSts = 0;
    stsChk();
    // Multiple mode: the upper half is compared inside, the lower half outside.
    wr(REG_MASK_LOW, 16'hFFFF);
    wr(REG_CONTROL, 16'h0001);
    lo = 16'($urandom);
    extCmpAddr <= lo;
    extCmpOn <= 1'b1;
    base = nBreaks;
    bus({cmp[31:16] ^ 16'h0100, lo}, 1'b1, 1'b0, 1'b0, 1'b0);
    waitIdle();
    bus({cmp[31:16], lo}, 1'b1, 1'b0, 1'b0, 1'b0);
    waitIdle();
    chk(16'(nBreaks - base), 16'h0001);
    mSts = 5;
    stsChk();
    chk(16'(nSeen), 16'h0004);
    print_verdict();
  end
endmodule : test_emulation_break_status_logic
`default_nettype wire
